// *** rtl/vpss_top.sv ***
// Variable phase shift handshake, lock and status logic of the clock manager.
//
// Function
// - Shift starts from the signed initial value, -255 to +255.
// - Direction is sampled on adjust clock; high increments, low decrements.
// - Each enabled cycle with direction high adds one fine delay increment.
// - Each enabled cycle with direction low subtracts one fine delay increment.
// - Change applied within 100 reference plus 3 adjust cycles, then one-cycle done.
// - Done is adjust-clock synchronous and signals completion and readiness.
// - All adjustment operations are paced by the adjust clock input.
// - Enable, adjust clock and direction each have selectable polarity.
// - Step count limited by 10 or 15 times (period minus 3).
// - Manager reset returns the step count to zero.
// - Manager reset returns handshake, step, lock, timer and status to power-on, drives lock low; startup and shift outputs reset only by rst_n_i.
// - Manager reset leaves configured attribute values unchanged.
// - Lock high when reference and feedback are aligned, low otherwise.
// - Status bit 1 flags stopped reference, only with feedback and delay-loop outputs.
// - Status bit 2 flags stopped synthesized output, only when connected.
// - Hold-until-lock keeps startup waiting until all flagged managers lock.
// - A selectable startup cycle among six is where the sequence stalls.
`timescale 1ns/1ps
module vpss_top
    import vpss_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic              phase_adjust_clock_i,
    input  wire logic              phase_adjust_enable_i,
    input  wire logic              step_direction_i,
    input  wire logic              reference_clock_in_i,
    input  wire logic              feedback_clock_in_i,
    input  wire logic              synth_clock_out_i,
    input  wire logic              manager_reset_i,
    input  wire logic              peer_locked_i,
    input  wire logic [1:0]        shift_mode_select_i,
    input  wire logic signed [8:0] initial_shift_i,
    input  wire logic              invert_enable_i,
    input  wire logic              invert_adjust_clock_i,
    input  wire logic              invert_direction_i,
    input  wire logic [7:0]        ref_period_ns_i,
    input  wire logic              ref_fast_i,
    input  wire logic              feedback_connected_i,
    input  wire logic              delay_outputs_used_i,
    input  wire logic              synth_connected_i,
    input  wire logic              startup_wait_i,
    input  wire logic [2:0]        startup_stall_cycle_i,
    output logic                   phase_adjust_done_o,
    output logic signed [12:0]     step_count_o,
    output logic signed [13:0]     current_shift_o,
    output logic                   locked_o,
    output logic [7:0]             status_o,
    output logic [2:0]             startup_cycle_o,
    output logic                   startup_done_o
);

    vpss_pin_if pins ();

    // The eight clock, adjust, reset and lock pins cross into the sampling clock through two flip-flops.
    vpss_pin_sync u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .pins_i  ({peer_locked_i, manager_reset_i, synth_clock_out_i, feedback_clock_in_i,
                   reference_clock_in_i, step_direction_i, phase_adjust_enable_i, phase_adjust_clock_i}),
        .pins    (pins)
    );

    // Signed step limit from the reference period; periods of 3 ns or less give no range.
    function automatic logic signed [STEP_W-1:0] step_limit(input logic [7:0] period, input logic fast);
        logic [7:0]  term;
        logic [11:0] prod;
        term = (period > LIMIT_OFFSET_NS) ? 8'(period - LIMIT_OFFSET_NS) : 8'h00;
        // Widen before the product so the multiply cannot wrap at eight bits.
        prod = fast ? 12'(term) * 12'(LIMIT_FAST_MUL) : 12'(term) * 12'(LIMIT_SLOW_MUL);
        return $signed({1'b0, prod});
    endfunction : step_limit

    // Polarity selection; an inverted adjust clock is active on the falling pin edge.
    wire adj_edge  = invert_adjust_clock_i ? pins.fall[PIN_ADJ_CLK] : pins.rise[PIN_ADJ_CLK];
    wire adj_en    = pins.lvl[PIN_ADJ_EN] ^ invert_enable_i;
    wire adj_dir   = pins.lvl[PIN_ADJ_DIR] ^ invert_direction_i;
    wire ref_rise  = pins.rise[PIN_REF];
    wire fb_rise   = pins.rise[PIN_FB];
    wire synth_tgl = pins.rise[PIN_SYNTH] | pins.fall[PIN_SYNTH];
    wire mgr_rst   = pins.lvl[PIN_MGR_RST];
    wire peer_lock = pins.lvl[PIN_PEER_LOCK];

    // Clear of handshake, step, done, lock, timer and status logic: the sampling reset or the manager reset; configuration ports are never touched.
    wire clear = !rst_n_i || mgr_rst;

    vpss_adj_state_type state;
    vpss_adj_state_type next_state;
    logic [6:0]              wait_cnt;
    logic                    req_dir;
    logic signed [STEP_W-1:0] step;

    // Request decode: only the variable mode listens to the adjust inputs.
    wire variable_mode = (shift_mode_select_i == SHIFT_MODE_VARIABLE);
    wire ready         = (state == ADJ_IDLE) || (state == ADJ_DONE);
    wire take_req      = ready && adj_edge && adj_en && variable_mode;
    wire ref_last      = (state == ADJ_REF_WAIT) && ref_rise && (wait_cnt == SETTLE_REF_CYCLES - 7'h01);
    wire adj_last      = (state == ADJ_CLK_WAIT) && adj_edge && (wait_cnt == ADJ_TAIL_CYCLES - 7'h01);
    wire signed [STEP_W-1:0] limit = step_limit(ref_period_ns_i, ref_fast_i);
    wire at_top        = (step >= limit);
    wire at_bottom     = (step <= -limit);
    wire apply_step    = ref_last;

    // Next state of the handshake.
    always_comb begin
        next_state = state;
        case (state)
            ADJ_IDLE: begin
                if (take_req) begin
                    next_state = ADJ_REF_WAIT;
                end
            end
            ADJ_REF_WAIT: begin
                if (ref_last) begin
                    next_state = ADJ_CLK_WAIT;
                end
            end
            ADJ_CLK_WAIT: begin
                if (adj_last) begin
                    next_state = ADJ_DONE;
                end
            end
            ADJ_DONE: begin
                if (take_req) begin
                    next_state = ADJ_REF_WAIT;
                end else if (adj_edge) begin
                    next_state = ADJ_IDLE;
                end
            end
            default: begin
                next_state = ADJ_IDLE;
            end
        endcase
    end

    // State register and the shared wait counter.
    always_ff @(posedge mclk_i) begin
        if (clear) begin
            state    <= ADJ_IDLE;
            wait_cnt <= 7'h00;
            req_dir  <= 1'b0;
        end else begin
            state <= next_state;
            if (take_req) begin
                req_dir <= adj_dir;
            end
            if (next_state != state) begin
                wait_cnt <= 7'h00;
            end else if ((state == ADJ_REF_WAIT && ref_rise) || (state == ADJ_CLK_WAIT && adj_edge)) begin
                wait_cnt <= wait_cnt + 7'h01;
            end
        end
    end

    // Step count update; a request at the limit is absorbed but still completes.
    always_ff @(posedge mclk_i) begin
        if (clear) begin
            step <= STEP_RESET;
        end else if (apply_step && req_dir && !at_top) begin
            step <= step + 13'sh0001;
        end else if (apply_step && !req_dir && !at_bottom) begin
            step <= step - 13'sh0001;
        end else if (at_top && step > limit) begin
            step <= limit;
        end else if (at_bottom && step < -limit) begin
            step <= -limit;
        end
    end

    // Done rises on an adjust clock edge and falls on the next one, so it lasts one adjust cycle.
    always_ff @(posedge mclk_i) begin
        if (clear) begin
            phase_adjust_done_o <= 1'b0;
        end else if (adj_last) begin
            phase_adjust_done_o <= 1'b1;
        end else if (adj_edge) begin
            phase_adjust_done_o <= 1'b0;
        end
    end

    // Registered shift outputs; the total shift is the initial value plus accumulated steps.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            step_count_o    <= STEP_RESET;
            current_shift_o <= 14'sh0000;
        end else begin
            step_count_o    <= step;
            current_shift_o <= 14'(initial_shift_i) + 14'(step);
        end
    end

    logic [3:0] fb_age;
    logic [3:0] match_cnt;
    logic [7:0] ref_age;
    logic [7:0] synth_age;

    // Lock detection: feedback must rise within a short window of each reference rise.
    wire aligned   = fb_rise || (fb_age < LOCK_WINDOW);
    wire ref_stop  = (ref_age == STOP_CYCLES);
    wire syn_stop  = (synth_age == STOP_CYCLES);
    always_ff @(posedge mclk_i) begin
        if (clear) begin
            fb_age    <= LOCK_WINDOW;
            match_cnt <= 4'h0;
            locked_o  <= 1'b0;
        end else begin
            fb_age <= fb_rise ? 4'h0 : ((fb_age < LOCK_WINDOW) ? fb_age + 4'h1 : fb_age);
            if (ref_stop) begin
                match_cnt <= 4'h0;
                locked_o  <= 1'b0;
            end else if (ref_rise && !aligned) begin
                match_cnt <= 4'h0;
                locked_o  <= 1'b0;
            end else if (ref_rise && match_cnt < LOCK_MATCHES) begin
                match_cnt <= match_cnt + 4'h1;
            end else if (match_cnt == LOCK_MATCHES) begin
                locked_o <= 1'b1;
            end
        end
    end

    // Stopped-clock timers saturate; a frozen clock can only be told from a slow one by timeout.
    always_ff @(posedge mclk_i) begin
        if (clear) begin
            ref_age   <= 8'h00;
            synth_age <= 8'h00;
        end else begin
            ref_age   <= ref_rise ? 8'h00 : (ref_stop ? ref_age : ref_age + 8'h01);
            synth_age <= synth_tgl ? 8'h00 : (syn_stop ? synth_age : synth_age + 8'h01);
        end
    end

    // Status bus with reserved bits held low.
    wire ref_flag   = ref_stop && feedback_connected_i && delay_outputs_used_i;
    wire synth_flag = syn_stop && synth_connected_i;
    always_ff @(posedge mclk_i) begin
        if (clear) begin
            status_o <= STATUS_RESET;
        end else begin
            status_o                  <= STATUS_RESET;
            status_o[STAT_REF_STOP]   <= ref_flag;
            status_o[STAT_SYNTH_STOP] <= synth_flag;
        end
    end

    logic [4:0] div_cnt;

    // Startup sequencer steps once per divider pulse and may stall at the chosen cycle.
    wire tick      = (div_cnt == STARTUP_DIV);
    wire all_lock  = (!startup_wait_i || locked_o) && peer_lock;
    wire stall     = startup_wait_i && (startup_cycle_o == startup_stall_cycle_i) && !all_lock;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            div_cnt         <= 5'h00;
            startup_cycle_o <= 3'h0;
            startup_done_o  <= 1'b0;
        end else begin
            div_cnt <= tick ? 5'h00 : div_cnt + 5'h01;
            if (tick && !startup_done_o && !stall) begin
                if (startup_cycle_o == STARTUP_LAST) begin
                    startup_done_o <= 1'b1;
                end else begin
                    startup_cycle_o <= startup_cycle_o + 3'h1;
                end
            end
        end
    end

    // Checks of the handshake, step arithmetic, status and startup.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    property p_done_one_cycle;
        phase_adjust_done_o && adj_edge && !adj_last && !mgr_rst |=> !phase_adjust_done_o;
    endproperty
    a_done_one_cycle: assert property (p_done_one_cycle) else $error("done outlived one adjust cycle");

    property p_done_on_edge;
        $rose(phase_adjust_done_o) |-> $past(adj_edge) && $past(state) == ADJ_CLK_WAIT;
    endproperty
    a_done_on_edge: assert property (p_done_on_edge) else $error("done rose off an adjust edge");

    property p_inc;
        apply_step && req_dir && !at_top && !mgr_rst |=> step == $past(step) + 13'sh0001;
    endproperty
    a_inc: assert property (p_inc) else $error("increment not applied");

    property p_dec;
        apply_step && !req_dir && !at_bottom && !mgr_rst |=> step == $past(step) - 13'sh0001;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement not applied");

    property p_clamp;
        apply_step && req_dir && step == limit && $stable(limit) && !mgr_rst |=> step == $past(step);
    endproperty
    a_clamp: assert property (p_clamp) else $error("step passed the limit");

    property p_limit_fn;
        ref_period_ns_i == 8'h04 |-> limit == (ref_fast_i ? 13'sh000f : 13'sh000a);
    endproperty
    a_limit_fn: assert property (p_limit_fn) else $error("limit term wrong");

    property p_mgr_reset;
        mgr_rst |=> step == STEP_RESET && !locked_o && state == ADJ_IDLE;
    endproperty
    a_mgr_reset: assert property (p_mgr_reset) else $error("manager reset incomplete");

    property p_reserved;
        status_o[0] == 1'b0 && status_o[7:3] == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bit set");

    property p_ref_stop_gate;
        !feedback_connected_i ##1 !feedback_connected_i |-> !status_o[STAT_REF_STOP];
    endproperty
    a_ref_stop_gate: assert property (p_ref_stop_gate) else $error("ref stopped flag not gated");

    property p_mode_gate;
        ready && adj_edge && !variable_mode && !mgr_rst |=> state != ADJ_REF_WAIT;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("request taken outside variable mode");

    property p_stall;
        tick && stall && !startup_done_o |=> $stable(startup_cycle_o) && !startup_done_o;
    endproperty
    a_stall: assert property (p_stall) else $error("startup passed the stall cycle");

    c_done:    cover property ($rose(phase_adjust_done_o));
    c_clamp:   cover property (apply_step && at_top && req_dir);
    c_lock:    cover property ($rose(locked_o));
    c_startup: cover property ($rose(startup_done_o));

endmodule : vpss_top

// *** pkg/vpss_pkg.sv ***
// Shared constants, pin indices and state type of the variable phase shift and status block.
package vpss_pkg;

    // Period of the sampling clock, in ns.
    localparam int unsigned MCLK_PERIOD_NS = 100;

    // Positions of the external pins inside the synchroniser vector.
    localparam int unsigned PIN_COUNT     = 8;
    localparam int unsigned PIN_ADJ_CLK   = 0;
    localparam int unsigned PIN_ADJ_EN    = 1;
    localparam int unsigned PIN_ADJ_DIR   = 2;
    localparam int unsigned PIN_REF       = 3;
    localparam int unsigned PIN_FB        = 4;
    localparam int unsigned PIN_SYNTH     = 5;
    localparam int unsigned PIN_MGR_RST   = 6;
    localparam int unsigned PIN_PEER_LOCK = 7;

    // Shift mode selection codes.
    localparam logic [1:0] SHIFT_MODE_NONE     = 2'h0;
    localparam logic [1:0] SHIFT_MODE_FIXED    = 2'h1;
    localparam logic [1:0] SHIFT_MODE_VARIABLE = 2'h2;

    // Adjustment timing: reference edges to settle, then adjust clock edges before done.
    localparam logic [6:0] SETTLE_REF_CYCLES = 7'h64;
    localparam logic [6:0] ADJ_TAIL_CYCLES   = 7'h03;

    // Step limit terms and the reference rate threshold.
    localparam int unsigned REF_FAST_MHZ    = 60;
    localparam logic [7:0]  LIMIT_OFFSET_NS = 8'h03;
    localparam logic [3:0]  LIMIT_SLOW_MUL  = 4'ha;
    localparam logic [3:0]  LIMIT_FAST_MUL  = 4'hf;
    localparam int unsigned STEP_W          = 13;

    // Stopped-clock detection time and its cycle count, rounded down.
    localparam int unsigned STOP_TIME_NS = 6400;
    localparam logic [7:0]  STOP_CYCLES  = 8'(STOP_TIME_NS / MCLK_PERIOD_NS);

    // Lock detection: alignment window and consecutive matches needed.
    localparam logic [3:0] LOCK_WINDOW  = 4'h2;
    localparam logic [3:0] LOCK_MATCHES = 4'h4;

    // Startup sequencer: six cycles, one step per divider pulse.
    localparam logic [2:0] STARTUP_LAST = 3'h5;
    localparam logic [4:0] STARTUP_DIV  = 5'h0f;

    // Reset values of the step count and status bus.
    localparam logic [STEP_W-1:0] STEP_RESET   = 13'h0000;
    localparam logic [7:0]        STATUS_RESET = 8'h00;
    localparam int unsigned       STAT_REF_STOP   = 1;
    localparam int unsigned       STAT_SYNTH_STOP = 2;

    // States of the adjustment handshake.
    typedef enum logic [1:0] {
        ADJ_IDLE,
        ADJ_REF_WAIT,
        ADJ_CLK_WAIT,
        ADJ_DONE
    } vpss_adj_state_type;

endpackage : vpss_pkg

// *** pkg/vpss_pin_if.sv ***
// Carrier for synchronised pin levels and their edges between the synchroniser and the core.
`timescale 1ns/1ps
interface vpss_pin_if;
    import vpss_pkg::*;
    logic [PIN_COUNT-1:0] lvl;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;

    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface : vpss_pin_if

// *** rtl/vpss_pin_sync.sv ***
// Two-stage synchroniser and edge finder for the eight clock, adjust, reset and lock pins of the block.
`timescale 1ns/1ps
module vpss_pin_sync
    import vpss_pkg::*;
(
    input  wire logic                 mclk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [PIN_COUNT-1:0] pins_i,
    vpss_pin_if.src                   pins
);

    logic [PIN_COUNT-1:0] stage1;
    logic [PIN_COUNT-1:0] stage2;
    logic [PIN_COUNT-1:0] stage3;

    // Only stage2 reads stage1; edges are taken between stage2 and stage3 so both see the same delay.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= pins_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Levels and one-cycle edge pulses.
    assign pins.lvl  = stage2;
    assign pins.rise = stage2 & ~stage3;
    assign pins.fall = ~stage2 & stage3;

endmodule : vpss_pin_sync

// *** dv/vpss_user_model.sv ***
// Behavioural user logic that issues phase adjust requests on its own adjust clock.
`timescale 1ns/1ps
module vpss_user_model (
    input  wire logic inv_en_i,
    input  wire logic inv_clk_i,
    input  wire logic inv_dir_i,
    input  wire logic done_i,
    output logic      adj_clk_o,
    output logic      adj_en_o,
    output logic      adj_dir_o
);
    logic clk = 1'b0;
    logic en  = 1'b0;
    logic dir = 1'b0;

    // Free-running 800 ns adjust clock, offset so its edges never meet the sampling clock.
    initial begin
        #37;
        forever #400 clk = ~clk;
    end

    // Pin levels follow the configured polarity, so the logical protocol stays the same.
    assign adj_clk_o = clk ^ inv_clk_i;
    assign adj_en_o  = en ^ inv_en_i;
    assign adj_dir_o = dir ^ inv_dir_i;

    // One enabled cycle, then a bounded wait for done and a check that it lasts one cycle.
    // Enable and direction move on the falling edge, so they stand half a cycle around the sampled rise.
    task automatic request(input logic d, output logic got, output logic one_cycle);
        int n;
        got = 1'b0;
        one_cycle = 1'b0;
        @(negedge clk);
        en = 1'b1;
        dir = d;
        @(negedge clk);
        en = 1'b0;
        // The direction line is left changing so a stale level cannot pass for a held one.
        dir = ~d;
        for (n = 0; n < 60 && !got; n++) begin
            @(posedge clk);
            got = (done_i === 1'b1);
        end
        @(posedge clk);
        one_cycle = got && (done_i === 1'b0);
    endtask : request
endmodule : vpss_user_model

// *** dv/tb_top.sv ***
// Self-checking bench of the phase adjust handshake, lock, status and startup logic.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin errors++; \
$display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top
    import vpss_pkg::*;
;
    typedef struct packed {
        logic [1:0] mode;
        logic       ie, ic, id, dir, done;
        logic [1:0] dlt;
    } vpss_row_type;

    // After the mode: invert enable, clock, direction; direction; done expected; step delta.
    vpss_row_type rows [8] = '{
        {SHIFT_MODE_VARIABLE, 7'b0001101}, {SHIFT_MODE_VARIABLE, 7'b0000111},
        {SHIFT_MODE_VARIABLE, 7'b1001101}, {SHIFT_MODE_VARIABLE, 7'b0100111},
        {SHIFT_MODE_VARIABLE, 7'b0011101}, {SHIFT_MODE_VARIABLE, 7'b1110111},
        {SHIFT_MODE_NONE, 7'b0001000},     {SHIFT_MODE_FIXED, 7'b0001000}};

    logic               mclk      = 1'b0;
    logic               rst_n     = 1'b0;
    logic               ph        = 1'b0;
    logic               ref_clk   = 1'b0;
    logic               synth_clk = 1'b0;
    logic               ref_run   = 1'b1;
    logic               syn_run   = 1'b1;
    logic               mgr_rst   = 1'b0;
    logic               peer_lock = 1'b0;
    logic [1:0]         mode      = SHIFT_MODE_VARIABLE;
    logic               inv_en    = 1'b0;
    logic               inv_clk   = 1'b0;
    logic               inv_dir   = 1'b0;
    logic               fast      = 1'b0;
    logic               fb_con    = 1'b1;
    logic               syn_con   = 1'b1;
    logic               adj_clk, adj_en, adj_dir, done, locked, su_done, got, one;
    logic signed [12:0] step;
    logic signed [13:0] shift;
    logic [7:0]         status;
    logic [2:0]         su_cycle;
    int                 errors = 0, compares = 0, exp_step = 0, lim;

    always #50 mclk = ~mclk;

    // Monitored clocks at 400 ns; feedback is the reference itself, so the loop is aligned.
    always @(posedge mclk) begin
        ph <= ~ph;
        if (ph) begin
            ref_clk   <= ref_clk ^ ref_run;
            synth_clk <= synth_clk ^ syn_run;
        end
    end

    vpss_top i_vpss_top (
        .mclk_i(mclk), .rst_n_i(rst_n), .phase_adjust_clock_i(adj_clk),
        .phase_adjust_enable_i(adj_en), .step_direction_i(adj_dir),
        .reference_clock_in_i(ref_clk), .feedback_clock_in_i(ref_clk), .synth_clock_out_i(synth_clk),
        .manager_reset_i(mgr_rst), .peer_locked_i(peer_lock), .shift_mode_select_i(mode),
        .initial_shift_i(9'h101), .invert_enable_i(inv_en), .invert_adjust_clock_i(inv_clk),
        .invert_direction_i(inv_dir), .ref_period_ns_i(8'h04), .ref_fast_i(fast),
        .feedback_connected_i(fb_con), .delay_outputs_used_i(1'b1), .synth_connected_i(syn_con),
        .startup_wait_i(1'b1), .startup_stall_cycle_i(3'h2), .phase_adjust_done_o(done),
        .step_count_o(step), .current_shift_o(shift), .locked_o(locked), .status_o(status),
        .startup_cycle_o(su_cycle), .startup_done_o(su_done)
    );

    vpss_user_model i_vpss_user_model (
        .inv_en_i(inv_en), .inv_clk_i(inv_clk), .inv_dir_i(inv_dir), .done_i(done),
        .adj_clk_o(adj_clk), .adj_en_o(adj_en), .adj_dir_o(adj_dir)
    );

    task automatic conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // One request through the user model, then done, step and shift against the expectation.
    task automatic adjust(input logic d, input logic ex_done);
        i_vpss_user_model.request(d, got, one);
        repeat (2) @(posedge mclk);
        `CHK("done", ex_done, got);
        `CHK("done width", ex_done, one);
        `CHK("step", 13'(exp_step), step);
        `CHK("shift", 14'(exp_step - 255), shift);
    endtask : adjust

    // The whole sequence needs about 1.2 ms; two and a half times that means something hangs.
    initial begin
        #3_000_000;
        errors++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        // Startup must sit at cycle 2 until the other managers report lock.
        repeat (80) @(posedge mclk);
        `CHK("startup cycle", 3'h2, su_cycle);
        `CHK("startup done", 1'b0, su_done);
        `CHK("locked", 1'b1, locked);
        `CHK("status", 8'h00, status);
        peer_lock <= 1'b1;
        repeat (100) @(posedge mclk);
        `CHK("startup done", 1'b1, su_done);
        $display("test startup finished");
        foreach (rows[i]) begin
            // Polarity changes only while requests are refused, so a stray edge cannot start one.
            @(posedge mclk);
            mode    <= SHIFT_MODE_NONE;
            inv_en  <= rows[i].ie;
            inv_clk <= rows[i].ic;
            inv_dir <= rows[i].id;
            repeat (4) @(posedge mclk);
            mode <= rows[i].mode;
            repeat (4) @(posedge mclk);
            exp_step = exp_step + int'($signed(rows[i].dlt));
            adjust(rows[i].dir, rows[i].done);
        end
        $display("test request table finished");
        // A manager reset clears step and lock but leaves the configured shift alone.
        mgr_rst <= 1'b1;
        mode    <= SHIFT_MODE_VARIABLE;
        repeat (20) @(posedge mclk);
        `CHK("step", 13'h0000, step);
        `CHK("locked", 1'b0, locked);
        mgr_rst <= 1'b0;
        repeat (60) @(posedge mclk);
        `CHK("locked", 1'b1, locked);
        `CHK("shift", 14'h3f01, shift);
        exp_step = 0;
        $display("test manager reset finished");
        // Push past both limits: 10 steps with a slow reference, then 15 with a fast one.
        for (int i = 0; i < 18; i++) begin
            if (i == 12) begin
                fast <= 1'b1;
            end
            lim = (i < 12) ? 10 : 15;
            exp_step = (exp_step < lim) ? exp_step + 1 : lim;
            adjust(1'b1, 1'b1);
        end
        $display("test step limit finished");
        // Stop flags need 64 idle cycles; without connections they must stay low.
        ref_run <= 1'b0;
        syn_run <= 1'b0;
        repeat (80) @(posedge mclk);
        `CHK("status", 8'h06, status);
        `CHK("locked", 1'b0, locked);
        fb_con  <= 1'b0;
        syn_con <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK("status", 8'h00, status);
        $display("test status finished");
        conclude();
    end
endmodule : tb_top
